/* File: dtcc_pkg.sv */
// constants and types for the dual time-base capture/compare block
// What this block does
// - sixteen channels, one-clock resolution, eight clocks when staggered
// - two independent 16-bit time-base timers, each with reload register
// - timer clock picks a prescaled system clock or neighbour overflow
// - first timer may also count an external count input
// - sixteen registers, each on either timer; first ten capture or compare, other six compare only
// - ten registers own a pin: capture input or compare output
// - compare mode 0: interrupt only, several per period, pin untouched
// - compare mode 1: pin toggles on every match
// - compare mode 2: interrupt only, at most one per period
// - compare mode 3: pin set on match, cleared on overflow, once per period
// - double register: two registers toggle one pin on either match
// - single event option stops a channel after its first event
// - capture latches allocated timer on selected pin event
// - each capture raises that register's interrupt request
// - capture edge selectable: rising, falling or both
// - compare registers checked on every timer count, action on equality
package dtcc_pkg;

  localparam int          NCH         = 16;
  localparam int          NPIN        = 10;
  localparam int          TW          = 16;
  localparam int          NPAIR       = 8;

  localparam logic [2:0]  SEL_DIV1    = 3'h0;
  localparam logic [2:0]  SEL_DIV2    = 3'h1;
  localparam logic [2:0]  SEL_DIV4    = 3'h2;
  localparam logic [2:0]  SEL_DIV8    = 3'h3;
  localparam logic [2:0]  SEL_NBR     = 3'h4;
  localparam logic [2:0]  SEL_EXT     = 3'h5;

  localparam logic [1:0]  MODE_IRQ    = 2'h0;
  localparam logic [1:0]  MODE_TOG    = 2'h1;
  localparam logic [1:0]  MODE_IRQ1   = 2'h2;
  localparam logic [1:0]  MODE_SETCLR = 2'h3;

  localparam int          EDGE_RISE   = 0;
  localparam int          EDGE_FALL   = 1;

  localparam logic [15:0] TIM_RST     = 16'h0000;
  localparam logic [15:0] TIM_MAX     = 16'hffff;
  localparam logic [15:0] CCR_RST     = 16'h0000;
  localparam logic [2:0]  PRE_RST     = 3'h0;
  localparam logic [2:0]  STAG_LAST   = 3'h7;

endpackage

/* File: dtcc_top.sv */
// dual time-base capture/compare array with pin logic
`timescale 1ns/100ps
module dtcc_top #(
  parameter int P_NCH   = dtcc_pkg::NCH,
  parameter int P_NPIN  = dtcc_pkg::NPIN,
  parameter int P_NPAIR = dtcc_pkg::NPAIR
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire logic                    i_ce,
  input  wire logic                    i_stagger,
  input  wire logic                    i_run_a,
  input  wire logic                    i_run_b,
  input  wire logic [2:0]              i_clksel_a,
  input  wire logic [2:0]              i_clksel_b,
  input  wire logic [dtcc_pkg::TW-1:0] i_reload_a,
  input  wire logic [dtcc_pkg::TW-1:0] i_reload_b,
  input  wire logic                    i_nbr_ovf,
  input  wire logic                    i_ext_cnt,
  input  wire logic [P_NCH-1:0]        i_ch_tsel,
  input  wire logic [P_NCH-1:0]        i_ch_cap,
  input  wire logic [2*P_NCH-1:0]      i_ch_mode,
  input  wire logic [2*P_NCH-1:0]      i_ch_edge,
  input  wire logic [P_NCH-1:0]        i_ch_single,
  input  wire logic [P_NPAIR-1:0]      i_ch_dbl,
  input  wire logic [P_NCH-1:0]        i_wr,
  input  wire logic [dtcc_pkg::TW-1:0] i_wdata,
  input  wire logic [P_NPIN-1:0]       i_pin,
  output logic      [P_NPIN-1:0]       o_pin,
  output logic      [P_NPIN-1:0]       o_pin_oe,
  output logic      [P_NCH-1:0]        o_irq,
  output logic      [16*P_NCH-1:0]     o_ccr,
  output logic      [dtcc_pkg::TW-1:0] o_tim_a,
  output logic      [dtcc_pkg::TW-1:0] o_tim_b,
  output logic                         o_ovf_a,
  output logic                         o_ovf_b
);
  import dtcc_pkg::*;

  logic [2:0]       pre_reg;
  logic [TW-1:0]    tim_reg [2];
  logic [1:0]       tick;
  logic [1:0]       ovf;
  logic [1:0]       tick_q_reg;
  logic [1:0]       ovf_q_reg;
  logic             ext_s1_reg;
  logic             ext_s2_reg;
  logic             ext_s3_reg;
  logic [P_NPIN-1:0] pin_s1_reg;
  logic [P_NPIN-1:0] pin_s2_reg;
  logic [P_NPIN-1:0] pin_s3_reg;
  logic [TW-1:0]    ccr_reg [P_NCH];
  logic [P_NCH-1:0] armed_reg;
  logic [P_NCH-1:0] done_reg;
  logic [P_NCH-1:0] hit;
  logic [P_NCH-1:0] cap_ev;
  logic [P_NPIN-1:0] pin_reg;
  logic             stag_ok;

  // prescaled tick from a free counter
  function automatic logic presc_tick(input logic [2:0] sel, input logic [2:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      SEL_DIV1: t = 1'b1;
      SEL_DIV2: t = pre[0];
      SEL_DIV4: t = &pre[1:0];
      SEL_DIV8: t = &pre[2:0];
      default:  t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic [1:0] mode_of(input int c, input logic [2*P_NCH-1:0] m);
    return m[2*c +: 2];
  endfunction

  // prescaler and stagger slot counter
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pre_reg <= PRE_RST;
    end else if (i_ce) begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // external count input synchroniser
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else if (i_ce) begin
      ext_s1_reg <= i_ext_cnt;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign stag_ok = !i_stagger || (pre_reg == STAG_LAST);

  always_comb begin
    tick[0] = presc_tick(i_clksel_a, pre_reg);
    tick[1] = presc_tick(i_clksel_b, pre_reg);
    if (i_clksel_a == SEL_NBR) begin
      tick[0] = i_nbr_ovf;
    end
    if (i_clksel_b == SEL_NBR) begin
      tick[1] = i_nbr_ovf;
    end
    if (i_clksel_a == SEL_EXT) begin
      tick[0] = ext_s2_reg && !ext_s3_reg;
    end
    tick[0] = tick[0] && i_run_a && i_ce && stag_ok;
    tick[1] = tick[1] && i_run_b && i_ce && stag_ok;
    ovf[0]  = tick[0] && (tim_reg[0] == TIM_MAX);
    ovf[1]  = tick[1] && (tim_reg[1] == TIM_MAX);
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tim_reg[0] <= TIM_RST;
      tim_reg[1] <= TIM_RST;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (tick[t]) begin
          if (ovf[t]) begin
            tim_reg[t] <= (t == 0) ? i_reload_a : i_reload_b;
          end else begin
            tim_reg[t] <= tim_reg[t] + 16'h0001;
          end
        end
      end
    end
  end

  // count and overflow stage for compare
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_q_reg <= 2'h0;
      ovf_q_reg  <= 2'h0;
      o_ovf_a    <= 1'b0;
      o_ovf_b    <= 1'b0;
    end else if (i_ce) begin
      tick_q_reg <= tick;
      ovf_q_reg  <= ovf;
      o_ovf_a    <= ovf[0];
      o_ovf_b    <= ovf[1];
    end
  end

  assign o_tim_a = tim_reg[0];
  assign o_tim_b = tim_reg[1];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else if (i_ce) begin
      pin_s1_reg <= i_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  genvar c;
  generate
    for (c = 0; c < P_NCH; c++) begin : g_ch
      logic          tsel;
      logic [TW-1:0] tv;
      logic [1:0]    md;
      logic          once;
      assign tsel = i_ch_tsel[c];
      assign tv   = tim_reg[tsel];
      assign md   = mode_of(c, i_ch_mode);
      assign once = (md == MODE_IRQ1) || (md == MODE_SETCLR);

      if (c < P_NPIN) begin : g_cap
        logic rise;
        logic fall;
        assign rise = pin_s2_reg[c] && !pin_s3_reg[c];
        assign fall = !pin_s2_reg[c] && pin_s3_reg[c];
        assign cap_ev[c] = i_ce && i_ch_cap[c] && armed_reg[c]
                           && ((i_ch_edge[2*c+EDGE_RISE] && rise)
                           ||  (i_ch_edge[2*c+EDGE_FALL] && fall));
      end else begin : g_nocap
        assign cap_ev[c] = 1'b0;
      end

      assign hit[c] = i_ce && !i_ch_cap[c] && tick_q_reg[tsel] && armed_reg[c]
                      && (tv == ccr_reg[c]) && !(once && done_reg[c] && !ovf_q_reg[tsel]);

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          ccr_reg[c] <= CCR_RST;
        end else if (cap_ev[c]) begin
          ccr_reg[c] <= tv;
        end else if (i_ce && i_wr[c]) begin
          ccr_reg[c] <= i_wdata;
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          done_reg[c] <= 1'b0;
        end else if (hit[c]) begin
          done_reg[c] <= 1'b1;
        end else if (i_ce && ovf_q_reg[tsel]) begin
          done_reg[c] <= 1'b0;
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          armed_reg[c] <= 1'b1;
        end else if (i_ch_single[c] && (hit[c] || cap_ev[c])) begin
          armed_reg[c] <= 1'b0;
        end else if (i_ce && i_wr[c]) begin
          armed_reg[c] <= 1'b1;
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          o_irq[c] <= 1'b0;
        end else if (i_ce) begin
          o_irq[c] <= hit[c] || cap_ev[c];
        end
      end

      assign o_ccr[16*c +: 16] = ccr_reg[c];
    end

    for (c = 0; c < P_NPIN; c++) begin : g_pin
      logic       dbl;
      logic       tog;
      logic [1:0] md;
      assign md  = mode_of(c, i_ch_mode);
      if (c < P_NPAIR) begin : g_pair
        assign dbl = i_ch_dbl[c];
        assign tog = dbl ? (hit[c] || hit[c+P_NPAIR]) : (hit[c] && md == MODE_TOG);
      end else begin : g_solo
        assign dbl = 1'b0;
        assign tog = hit[c] && (md == MODE_TOG);
      end

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          pin_reg[c] <= 1'b0;
        end else if (tog) begin
          pin_reg[c] <= !pin_reg[c];
        end else if (!dbl && md == MODE_SETCLR && hit[c]) begin
          pin_reg[c] <= 1'b1;
        end else if (i_ce && !dbl && md == MODE_SETCLR && ovf_q_reg[i_ch_tsel[c]]) begin
          pin_reg[c] <= 1'b0;
        end
      end

      assign o_pin_oe[c] = !i_ch_cap[c]
                           && (dbl || md == MODE_TOG || md == MODE_SETCLR);
    end
  endgenerate

  assign o_pin = pin_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_wrap_b;
    tick[1] && (tim_reg[1] == TIM_MAX);
  endsequence

  sequence s_setclr_hit;
    hit[1] && !i_ch_dbl[1] && (i_ch_mode[3:2] == MODE_SETCLR);
  endsequence

  AST_TIM_RELOAD: assert property (s_wrap_b |=> tim_reg[1] == $past(i_reload_b))
    else $error("timer b did not reload on overflow");

  AST_STAG_SLOT: assert property (i_stagger && tick[1] |-> pre_reg == STAG_LAST)
    else $error("timer counted outside stagger slot");

  AST_CAP_LATCH: assert property (cap_ev[2] |=> ccr_reg[2] == $past(g_ch[2].tv))
    else $error("capture did not latch timer value");

  AST_CAP_IRQ: assert property (cap_ev[3] |=> o_irq[3])
    else $error("capture raised no request");

  AST_EDGE_RISE: assert property (
      i_ch_cap[2] && i_ch_edge[5:4] == 2'h1
      && !pin_s2_reg[2] && pin_s3_reg[2] |-> !cap_ev[2])
    else $error("falling edge captured in rising-only setting");

  AST_M0_PIN: assert property (
      i_ce && !i_ch_dbl[5] && i_ch_mode[11:10] == MODE_IRQ
      && $stable(i_ch_mode[11:10]) && $stable(i_ch_dbl[5]) |=> $stable(pin_reg[5]))
    else $error("pin moved in interrupt-only mode");

  AST_M1_TOGGLE: assert property (
      hit[0] && !i_ch_dbl[0] && i_ch_mode[1:0] == MODE_TOG
      |=> pin_reg[0] != $past(pin_reg[0]))
    else $error("pin did not toggle on match");

  AST_M2_ONCE: assert property (
      hit[4] && i_ch_mode[9:8] == MODE_IRQ1 && !ovf_q_reg[i_ch_tsel[4]]
      && !ovf[i_ch_tsel[4]] |=> done_reg[4] ##0 !hit[4])
    else $error("second interrupt in one period");

  AST_M3_SET: assert property (s_setclr_hit |=> pin_reg[1] ##1 1'b1)
    else $error("pin not set on match");

  AST_DBL: assert property (
      i_ch_dbl[6] && hit[14] && !hit[6]
      |=> pin_reg[6] != $past(pin_reg[6]))
    else $error("paired register did not toggle pin");

  AST_SINGLE: assert property (
      i_ch_single[5] && hit[5] && !i_wr[5]
      |=> !armed_reg[5] ##1 !hit[5])
    else $error("single event channel fired again");

  AST_CMP_EQ: assert property (
      hit[5] |-> g_ch[5].tv == ccr_reg[5]
      && $past(tick[i_ch_tsel[5]]))
    else $error("compare hit without count and equality");

endmodule // dtcc_top

/* File: dtcc_pins.sv */
// port pin model: capture stimulus and compare output edge counters
`timescale 1ns/100ps
module dtcc_pins (
  input  wire logic       i_clk,
  input  wire logic [9:0] i_out,
  input  wire logic [9:0] i_oe,
  output logic      [9:0] o_lvl
);
  logic [9:0] drv_reg  = 10'h000;
  logic [9:0] prev_reg = 10'h000;
  int         rise [10];
  int         fall [10];

  assign o_lvl = (i_oe & i_out) | (~i_oe & drv_reg);

  always @(posedge i_clk) begin
    for (int k = 0; k < 10; k++) begin
      if (i_out[k] === 1'b1 && prev_reg[k] === 1'b0) rise[k]++;
      if (i_out[k] === 1'b0 && prev_reg[k] === 1'b1) fall[k]++;
    end
    prev_reg <= i_out;
  end

  task automatic clear();
    for (int k = 0; k < 10; k++) begin
      rise[k] = 0;
      fall[k] = 0;
    end
  endtask

  // external transition launched at a clock edge
  task automatic set_pin(input int k, input logic v);
    @(posedge i_clk);
    drv_reg[k] <= v;
  endtask
endmodule // dtcc_pins

/* File: dtcc_top_bench.sv */
// self-checking bench for the dual time-base capture/compare block
`timescale 1ns/100ps
module dtcc_top_bench;
  import dtcc_pkg::*;
  logic          i_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_stagger = 1'b0;
  logic          i_run_a = 1'b1, i_run_b = 1'b1, i_nbr_ovf = 1'b0, i_ext_cnt = 1'b0;
  logic [2:0]    i_clksel_a = SEL_EXT, i_clksel_b = SEL_DIV1;
  logic [15:0]   i_reload_a = 16'h0000, i_reload_b = 16'hfff0, i_wdata = 16'h0000;
  logic [15:0]   i_ch_tsel = 16'h4473, i_ch_cap = 16'h000c, i_ch_single = 16'h0020;
  logic [15:0]   i_wr = 16'h0000;
  logic [31:0]   i_ch_mode = 32'h0000_020d, i_ch_edge = 32'h0000_0090;
  logic [7:0]    i_ch_dbl = 8'h40;
  logic [9:0]    i_pin, o_pin, o_pin_oe;
  logic [15:0]   o_irq, o_tim_a, o_tim_b;
  logic [255:0]  o_ccr;
  logic          o_ovf_a, o_ovf_b;
  int            n_mismatch = 0, comparisons = 0;
  int            nirq [16];

  always #25 i_clk = ~i_clk;

  dtcc_top dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_stagger(i_stagger),
    .i_run_a(i_run_a), .i_run_b(i_run_b), .i_clksel_a(i_clksel_a), .i_clksel_b(i_clksel_b),
    .i_reload_a(i_reload_a), .i_reload_b(i_reload_b), .i_nbr_ovf(i_nbr_ovf),
    .i_ext_cnt(i_ext_cnt), .i_ch_tsel(i_ch_tsel), .i_ch_cap(i_ch_cap), .i_ch_mode(i_ch_mode),
    .i_ch_edge(i_ch_edge), .i_ch_single(i_ch_single), .i_ch_dbl(i_ch_dbl), .i_wr(i_wr),
    .i_wdata(i_wdata), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_irq(o_irq),
    .o_ccr(o_ccr), .o_tim_a(o_tim_a), .o_tim_b(o_tim_b), .o_ovf_a(o_ovf_a), .o_ovf_b(o_ovf_b));

  dtcc_pins pins_u (.i_clk(i_clk), .i_out(o_pin), .i_oe(o_pin_oe), .o_lvl(i_pin));

  always @(posedge i_clk) begin
    for (int c = 0; c < 16; c++) begin
      if (o_irq[c] === 1'b1) nirq[c]++;
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s count %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic clear_all();
    #1;
    pins_u.clear();
    for (int c = 0; c < 16; c++) nirq[c] = 0;
  endtask

  task automatic wr(input int c, input logic [15:0] d);
    @(posedge i_clk);
    i_wr[c] <= 1'b1;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 16'h0000;
  endtask

  task automatic test_sources();
    chk_v(o_tim_a, TIM_RST, "timer a after reset");
    chk_v(o_ccr[15:0], CCR_RST, "ccr0 after reset");
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_ext_cnt <= 1'b1;
      tick(4);
      i_ext_cnt <= 1'b0;
      tick(3);
    end
    tick(5);
    chk_v(o_tim_a, 16'h0003, "external count");
    i_clksel_a <= SEL_NBR;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_nbr_ovf <= 1'b1;
      @(posedge i_clk);
      i_nbr_ovf <= 1'b0;
      tick(2);
    end
    chk_v(o_tim_a, 16'h0005, "neighbour count");
    i_clksel_a <= 3'h6;
  endtask

  task automatic test_capture();
    wr(3, 16'h1234);
    clear_all();
    pins_u.set_pin(2, 1'b1);
    pins_u.set_pin(3, 1'b1);
    tick(6);
    chk_v(o_ccr[47:32], 16'h0005, "rising capture");
    chk_v(o_ccr[63:48], 16'h1234, "falling-only ignores rise");
    chk_n(nirq[2], 1, "capture request");
    pins_u.set_pin(3, 1'b0);
    pins_u.set_pin(2, 1'b0);
    tick(6);
    chk_v(o_ccr[63:48], 16'h0005, "falling capture");
    chk_n(nirq[3], 1, "falling capture request");
    chk_n(nirq[2], 1, "rising-only ignores fall");
  endtask

  task automatic wait_ovf_b();
    int k;
    k = 0;
    while (o_ovf_b !== 1'b1 && k < 70000) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    if (k == 70000) begin
      n_mismatch++;
      $display("wrong value at %0t: timer b never wrapped", $time);
      wrap_up();
    end else begin
      chk_v(o_tim_b, 16'hfff0, "timer b after reload");
    end
  endtask

  task automatic test_freeze();
    @(posedge i_clk);
    i_ce <= 1'b0;
    tick(6);
    chk_v(o_tim_b, 16'hfff1, "timer held by clock enable");
    i_ce <= 1'b1;
  endtask

  task automatic test_compare();
    wr(0, 16'hfff4);
    wr(1, 16'hfff8);
    wr(4, 16'hfff2);
    wr(6, 16'hfff1);
    wr(14, 16'hfff9);
    wr(10, 16'hfffa);
    tick(20);
    chk_v({6'h00, o_pin_oe}, 16'h0043, "pin drive enables");
    clear_all();
    wr(5, 16'hfff6);
    tick(158);
    #1;
    chk_n(nirq[10], 10, "mode 0 requests");
    chk_n(pins_u.rise[0] + pins_u.fall[0], 10, "mode 1 toggles");
    chk_n(nirq[4], 10, "mode 2 requests");
    chk_n(pins_u.rise[1], 10, "mode 3 sets");
    chk_n(pins_u.fall[1], 10, "mode 3 clears");
    chk_n(pins_u.rise[6] + pins_u.fall[6], 20, "double register toggles");
    chk_n(nirq[5], 1, "single event");
    chk_n(nirq[7], 0, "stopped timer no hit");
  endtask

  task automatic test_stagger();
    @(posedge i_clk);
    i_stagger <= 1'b1;
    tick(8);
    clear_all();
    tick(1280);
    #1;
    chk_n(nirq[10], 10, "staggered requests");
  endtask

  initial begin
    tick(12);
    i_nrst <= 1'b1;
    tick(1);
    test_sources();
    test_capture();
    wait_ovf_b();
    test_compare();
    test_freeze();
    test_stagger();
    wrap_up();
  end
endmodule // dtcc_top_bench
